//--- hw/ascb_pkg.sv
/*
 * Constants and types shared by the serial control byte front end.
 * Assumes a single system clock; all serial pins are sampled by it.
 */
`default_nettype none

package ascb_pkg;

    // Control byte layout.
    localparam int          CTRL_BITS       = 8;
    localparam int          START_POS       = 7;
    localparam int          SEL_HI_POS      = 6;
    localparam int          SEL_LO_POS      = 4;
    localparam int          POL_POS         = 3;
    localparam int          CFG_POS         = 2;
    localparam int          MODE_HI_POS     = 1;
    localparam int          MODE_LO_POS     = 0;

    // Bit counts within the control byte and the result frame.
    localparam logic [3:0]  BIT_CNT_IDLE    = 4'h0;
    localparam logic [3:0]  BIT_CNT_FIRST   = 4'h1;
    localparam logic [3:0]  TRACK_BIT_CNT   = 4'h5;
    localparam logic [3:0]  HOLD_BIT_CNT    = 4'h8;
    localparam int          RESULT_W        = 10;
    localparam int          OUT_W           = 12;
    localparam logic [3:0]  OUT_BITS        = 4'hC;
    localparam logic [3:0]  OUT_CNT_ZERO    = 4'h0;
    localparam logic [3:0]  OUT_CNT_FIRST   = 4'h1;
    // A new start bit is accepted once result bit 3 has been shifted out.
    localparam logic [3:0]  RESTART_OUT_CNT = 4'h7;
    localparam logic [7:0]  START_SHIFT     = 8'h01;

    // Power and clock mode codes.
    localparam logic [1:0]  MODE_FULL_PD    = 2'h0;
    localparam logic [1:0]  MODE_FAST_PD    = 2'h1;
    localparam logic [1:0]  MODE_INT_CLK    = 2'h2;
    localparam logic [1:0]  MODE_EXT_CLK    = 2'h3;

    // Reset values.
    localparam logic [1:0]  MODE_RESET      = MODE_INT_CLK;
    localparam logic        STROBE_RESET    = 1'b1;
    // Synchroniser order is {data_in, chip_select_n, serial_clock}.
    localparam logic [2:0]  PIN_SYNC_RESET  = 3'h2;
    localparam int          PIN_CLK_IDX     = 0;
    localparam int          PIN_CSN_IDX     = 1;
    localparam int          PIN_DIN_IDX     = 2;

    localparam int          FIFO_DEPTH      = 32;

    typedef enum logic [3:0] {
        OUT_IDLE   = 4'h1,
        OUT_STROBE = 4'h2,
        OUT_WAIT   = 4'h4,
        OUT_SHIFT  = 4'h8
    } ascb_out_state_type;

endpackage

`default_nettype wire

//--- hw/ascb_sync.sv
/*
 * Two flip-flop synchroniser for a vector of independent levels.
 * Assumes each bit is a slow level or a clock far below the system clock.
 */
`default_nettype none

module ascb_sync #(
    parameter int                WIDTH     = 1,
    parameter logic [WIDTH-1:0]  RESET_VAL = '0
) (
    input  wire logic             clk_sys_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta;

    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                meta[i]   <= RESET_VAL[i];
                sync_o[i] <= RESET_VAL[i];
            end else begin
                meta[i]   <= async_i[i];
                sync_o[i] <= meta[i];
            end
        end
    end

endmodule

`default_nettype wire

//--- hw/ascb_fifo.sv
/*
 * Synchronous FIFO with valid and ready on both sides.
 * Assumes DEPTH is a power of two; full and empty come from flip-flops.
 */
`default_nettype none

module ascb_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 32
) (
    input  wire logic             clk_sys_i,
    input  wire logic             rst_n_i,
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  in_ready_o,
    output logic                  out_valid_o,
    output logic      [WIDTH-1:0] out_data_o,
    input  wire logic             out_ready_i
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW-1:0]    next_wr_ptr;
    logic [AW-1:0]    next_rd_ptr;
    logic [AW:0]      count;
    logic [AW:0]      next_count;
    logic             full;
    logic             empty;
    logic             next_full;
    logic             next_empty;
    logic             push;
    logic             pop;

    assign push        = in_valid_i & ~full;
    assign pop         = out_ready_i & ~empty;
    assign out_valid_o = ~empty;
    assign out_data_o  = mem[rd_ptr];

    always_comb begin
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
        next_count  = count;
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
        next_full  = (next_count == (AW+1)'(DEPTH));
        next_empty = (next_count == '0);
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
            full   <= 1'b0;
            empty  <= 1'b1;
            in_ready_o <= 1'b1;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
            full   <= next_full;
            empty  <= next_empty;
            in_ready_o <= ~next_full;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

endmodule

`default_nettype wire

//--- hw/ascb_top.sv
/*
 * Serial control byte front end of an 8-channel 10-bit converter.
 * Frames the control byte, steers the input multiplexer and sampler,
 * and drives the strobe and serial result pins.
 * Assumes serial pins are asynchronous to clk_sys_i and that the serial
 * clock runs well below a quarter of it; results come from an analog core.
 */
// Operation
// - With chip select low, each serial clock rise shifts in one data bit.
// - Leading zeros after chip select falls are ignored; first one is bit 7.
// - Bits 6 to 4 choose the analog channels used for conversion.
// - Bit 3 set means unipolar, clear means bipolar conversion.
// - Bit 2 set means single-ended against common return, clear differential.
// - Bits 1-0: full power-down, fast power-down, internal clock, external clock.
// - Single-ended codes map in shuffled order onto channels 0 to 7.
// - Differential codes pair even and odd channels; bit 6 picks which is positive.
// - An all-ones byte stream gives continuous unipolar single-ended channel 7 conversions.
// - External mode strobe is high one serial period before the first result bit.
// - With data held high each external conversion takes 15 serial clocks.
// - With chip select low, data out and external mode strobe change only on serial clock falls.
// - Data out changes on falling edges and floats while chip select is high.
// - Sampler tracks after the fifth control bit, holds after the eighth.
// - Internal mode strobe falls at conversion start and rises at its end.
// - Results go out msb first; unipolar straight binary, bipolar two's complement.
`default_nettype none

module ascb_top
    import ascb_pkg::*;
(
    input  wire logic                clk_sys_i,
    input  wire logic                rst_n_i,
    input  wire logic                serial_clock_i,
    input  wire logic                chip_select_n_i,
    input  wire logic                serial_data_in_i,
    output logic                     serial_data_out_o,
    output logic                     serial_data_out_oe_o,
    output logic                     conversion_strobe_o,
    output logic                     conversion_strobe_oe_o,
    output logic                     conv_start_o,
    output logic                     track_o,
    output logic                     hold_o,
    output logic [2:0]               pos_channel_o,
    output logic [2:0]               neg_channel_o,
    output logic                     neg_is_common_o,
    output logic                     bipolar_o,
    output logic [1:0]               power_clock_mode_o,
    output logic                     power_down_o,
    input  wire logic                result_valid_i,
    input  wire logic [RESULT_W-1:0] result_data_i,
    output logic                     result_ready_o
);

    // Positive channel number for a select code, same in both input modes.
    function automatic logic [2:0] chan_pos(input logic [2:0] sel);
        chan_pos = {sel[1], sel[0], sel[2]};
    endfunction

    // Result as it leaves the pin: sign bit flipped for bipolar, two pad bits.
    function automatic logic [OUT_W-1:0] pad_result(input logic [RESULT_W-1:0] d,
                                                    input logic bip);
        pad_result = {d[RESULT_W-1] ^ bip, d[RESULT_W-2:0], 2'b00};
    endfunction

    logic [2:0]          pins_s;
    logic                sclk_s;
    logic                csn_s;
    logic                din_s;

    logic                sclk_d;
    logic                csn_d;
    logic [CTRL_BITS-1:0] shift_reg;
    logic [3:0]          bit_cnt;
    logic                cs_cycled;
    logic                next_sclk_d;
    logic                next_csn_d;
    logic [CTRL_BITS-1:0] next_shift_reg;
    logic [3:0]          next_bit_cnt;
    logic                next_cs_cycled;

    logic                sclk_rise;
    logic                sclk_fall;
    logic                cs_rise;
    logic                start_ok;
    logic                launch;

    ascb_out_state_type  out_state;
    ascb_out_state_type  next_out_state;
    logic [OUT_W-1:0]    out_shift;
    logic [OUT_W-1:0]    next_out_shift;
    logic [3:0]          out_cnt;
    logic [3:0]          next_out_cnt;
    logic                next_dout;
    logic                next_dout_oe;
    logic                next_strobe;
    logic                next_strobe_oe;
    logic                next_conv_start;
    logic                next_track;
    logic                next_hold;
    logic [2:0]          next_pos;
    logic [2:0]          next_neg;
    logic                next_neg_com;
    logic                next_bipolar;
    logic [1:0]          next_mode;
    logic                next_power_down;
    logic [OUT_W-1:0]    padded;
    logic [2:0]          sel;

    logic                fifo_valid;
    logic [RESULT_W-1:0] fifo_data;
    logic                fifo_pop;

    ascb_sync #(
        .WIDTH     (3),
        .RESET_VAL (PIN_SYNC_RESET)
    ) u_sync (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .async_i   ({serial_data_in_i, chip_select_n_i, serial_clock_i}),
        .sync_o    (pins_s)
    );

    assign sclk_s = pins_s[PIN_CLK_IDX];
    assign csn_s  = pins_s[PIN_CSN_IDX];
    assign din_s  = pins_s[PIN_DIN_IDX];

    // Results wait here until the serial master clocks one out, or until OUT_WAIT takes one in internal clock mode.
    ascb_fifo #(
        .WIDTH (RESULT_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_i   (clk_sys_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (result_valid_i),
        .in_data_i   (result_data_i),
        .in_ready_o  (result_ready_o),
        .out_valid_o (fifo_valid),
        .out_data_o  (fifo_data),
        .out_ready_i (fifo_pop)
    );

    assign sclk_rise = sclk_s & ~sclk_d & ~csn_s;
    assign sclk_fall = ~sclk_s & sclk_d & ~csn_s;
    assign cs_rise   = csn_s & ~csn_d;
    assign launch    = sclk_fall && (bit_cnt == HOLD_BIT_CNT);
    assign sel       = shift_reg[SEL_HI_POS:SEL_LO_POS];

    // A start bit counts when idle, after a chip select cycle, or once the
    // running conversion has shifted result bit 3 out.
    assign start_ok  = cs_cycled || (out_state == OUT_IDLE) ||
                       ((out_state == OUT_SHIFT) && (out_cnt >= RESTART_OUT_CNT));

    // Framing of the control byte.
    always_comb begin
        next_sclk_d    = sclk_s;
        next_csn_d     = csn_s;
        next_shift_reg = shift_reg;
        next_bit_cnt   = bit_cnt;
        next_cs_cycled = cs_cycled;
        if (csn_s) begin
            next_bit_cnt = BIT_CNT_IDLE;
            if (cs_rise) begin
                next_cs_cycled = 1'b1;
            end
        end else if (sclk_rise) begin
            if (bit_cnt == BIT_CNT_IDLE) begin
                // Zeros before the start bit are dropped.
                if (din_s && start_ok) begin
                    next_shift_reg = START_SHIFT;
                    next_bit_cnt   = BIT_CNT_FIRST;
                    next_cs_cycled = 1'b0;
                end
            end else if (bit_cnt < HOLD_BIT_CNT) begin
                next_shift_reg = {shift_reg[CTRL_BITS-2:0], din_s};
                next_bit_cnt   = bit_cnt + 1'b1;
            end
        end else if (launch) begin
            next_bit_cnt = BIT_CNT_IDLE;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sclk_d    <= 1'b0;
            csn_d     <= 1'b1;
            shift_reg <= '0;
            bit_cnt   <= BIT_CNT_IDLE;
            cs_cycled <= 1'b1;
        end else begin
            sclk_d    <= next_sclk_d;
            csn_d     <= next_csn_d;
            shift_reg <= next_shift_reg;
            bit_cnt   <= next_bit_cnt;
            cs_cycled <= next_cs_cycled;
        end
    end

    // Conversion control, strobe and result shifting.
    always_comb begin
        next_out_state  = out_state;
        next_out_shift  = out_shift;
        next_out_cnt    = out_cnt;
        next_dout       = serial_data_out_o;
        next_dout_oe    = ~csn_s;
        next_strobe     = conversion_strobe_o;
        next_strobe_oe  = (power_clock_mode_o == MODE_EXT_CLK) ? ~csn_s : 1'b1;
        next_conv_start = 1'b0;
        next_track      = track_o;
        next_hold       = hold_o;
        next_pos        = pos_channel_o;
        next_neg        = neg_channel_o;
        next_neg_com    = neg_is_common_o;
        next_bipolar    = bipolar_o;
        next_mode       = power_clock_mode_o;
        next_power_down = power_down_o;
        fifo_pop        = 1'b0;
        padded          = pad_result(fifo_valid ? fifo_data : '0, bipolar_o);

        if (sclk_fall && (bit_cnt == TRACK_BIT_CNT)) begin
            next_track = 1'b1;
        end

        case (out_state)
            OUT_IDLE: begin
                next_out_cnt = OUT_CNT_ZERO;
            end
            OUT_STROBE: begin
                // The strobe period ends as the msb appears.
                if (sclk_fall) begin
                    fifo_pop       = fifo_valid;
                    next_strobe    = 1'b0;
                    next_dout      = padded[OUT_W-1];
                    next_out_shift = {padded[OUT_W-2:0], 1'b0};
                    next_out_cnt   = OUT_CNT_FIRST;
                    next_hold      = 1'b0;
                    next_out_state = OUT_SHIFT;
                end
            end
            OUT_WAIT: begin
                if (fifo_valid) begin
                    fifo_pop       = 1'b1;
                    next_strobe    = 1'b1;
                    next_out_shift = padded;
                    next_out_cnt   = OUT_CNT_ZERO;
                    next_hold      = 1'b0;
                    next_out_state = OUT_SHIFT;
                end
            end
            OUT_SHIFT: begin
                if (sclk_fall) begin
                    if (out_cnt == OUT_BITS) begin
                        next_dout      = 1'b0;
                        next_out_state = OUT_IDLE;
                    end else begin
                        next_dout      = out_shift[OUT_W-1];
                        next_out_shift = {out_shift[OUT_W-2:0], 1'b0};
                        next_out_cnt   = out_cnt + 1'b1;
                    end
                end
            end
            default: begin
                next_out_state = OUT_IDLE;
            end
        endcase

        // Raising chip select ends an external clock conversion; an internal
        // one keeps running and its result stays queued.
        if (cs_rise && (power_clock_mode_o == MODE_EXT_CLK) &&
            ((out_state == OUT_STROBE) || (out_state == OUT_SHIFT))) begin
            next_out_state = OUT_IDLE;
            next_strobe    = 1'b0;
            next_dout      = 1'b0;
            next_hold      = 1'b0;
        end

        // A completed control byte overrides whatever conversion is running.
        if (launch) begin
            next_mode    = shift_reg[MODE_HI_POS:MODE_LO_POS];
            next_bipolar = ~shift_reg[POL_POS];
            next_pos     = chan_pos(sel);
            next_track   = 1'b0;
            if (shift_reg[CFG_POS]) begin
                next_neg_com = 1'b1;
                next_neg     = '0;
            end else begin
                next_neg_com = 1'b0;
                next_neg     = {sel[1], sel[0], ~sel[2]};
            end
            case (shift_reg[MODE_HI_POS:MODE_LO_POS])
                MODE_EXT_CLK: begin
                    // An all-ones byte lands here: channel 7, unipolar, single-ended.
                    next_strobe     = 1'b1;
                    next_hold       = 1'b1;
                    next_conv_start = 1'b1;
                    next_power_down = 1'b0;
                    next_out_state  = OUT_STROBE;
                end
                MODE_INT_CLK: begin
                    next_strobe     = 1'b0;
                    next_hold       = 1'b1;
                    next_conv_start = 1'b1;
                    next_power_down = 1'b0;
                    next_out_state  = OUT_WAIT;
                end
                default: begin
                    next_hold       = 1'b0;
                    next_power_down = 1'b1;
                    next_dout       = 1'b0;
                    next_out_state  = OUT_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            out_state              <= OUT_IDLE;
            out_shift              <= '0;
            out_cnt                <= OUT_CNT_ZERO;
            serial_data_out_o      <= 1'b0;
            serial_data_out_oe_o   <= 1'b0;
            conversion_strobe_o    <= STROBE_RESET;
            conversion_strobe_oe_o <= 1'b1;
            conv_start_o           <= 1'b0;
            track_o                <= 1'b0;
            hold_o                 <= 1'b0;
            pos_channel_o          <= '0;
            neg_channel_o          <= '0;
            neg_is_common_o        <= 1'b1;
            bipolar_o              <= 1'b0;
            power_clock_mode_o     <= MODE_RESET;
            power_down_o           <= 1'b0;
        end else begin
            out_state              <= next_out_state;
            out_shift              <= next_out_shift;
            out_cnt                <= next_out_cnt;
            serial_data_out_o      <= next_dout;
            serial_data_out_oe_o   <= next_dout_oe;
            conversion_strobe_o    <= next_strobe;
            conversion_strobe_oe_o <= next_strobe_oe;
            conv_start_o           <= next_conv_start;
            track_o                <= next_track;
            hold_o                 <= next_hold;
            pos_channel_o          <= next_pos;
            neg_channel_o          <= next_neg;
            neg_is_common_o        <= next_neg_com;
            bipolar_o              <= next_bipolar;
            power_clock_mode_o     <= next_mode;
            power_down_o           <= next_power_down;
        end
    end

endmodule

`default_nettype wire

//--- tb/ascb_top_asserts.sv
/* Port checker for the serial control byte front end.
 * Assumes it is bound to ascb_top and sees only its ports. */
`default_nettype none
module ascb_top_asserts
    import ascb_pkg::*;
(
    input wire logic       clk_sys_i,
    input wire logic       rst_n_i,
    input wire logic       chip_select_n_i,
    input wire logic       serial_clock_i,
    input wire logic       serial_data_out_o,
    input wire logic       serial_data_out_oe_o,
    input wire logic       conversion_strobe_o,
    input wire logic       conversion_strobe_oe_o,
    input wire logic       conv_start_o,
    input wire logic       track_o,
    input wire logic       hold_o,
    input wire logic [2:0] pos_channel_o,
    input wire logic [2:0] neg_channel_o,
    input wire logic       neg_is_common_o,
    input wire logic [1:0] power_clock_mode_o,
    input wire logic       power_down_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    dout_float_a: assert property (chip_select_n_i [*5] |-> !serial_data_out_oe_o)
        else $error("data out driven while deselected");
    strb_float_a: assert property ((chip_select_n_i && power_clock_mode_o == MODE_EXT_CLK) [*5]
        |-> !conversion_strobe_oe_o) else $error("strobe driven while deselected");
    start_hold_a: assert property (conv_start_o |-> hold_o && $past(track_o))
        else $error("conversion start without track then hold");
    start_mode_a: assert property (conv_start_o |-> power_clock_mode_o[1])
        else $error("conversion in power-down mode");
    pd_flag_a: assert property (power_down_o == !power_clock_mode_o[1])
        else $error("power-down flag disagrees with mode");
    common_neg_a: assert property (neg_is_common_o |-> neg_channel_o == 3'h0)
        else $error("common negative channel not zero");
    pair_sel_a: assert property (!neg_is_common_o |-> pos_channel_o == {neg_channel_o[2:1], !neg_channel_o[0]})
        else $error("differential pair mismatch");
    strobe_width_a: assert property ($rose(conversion_strobe_o) && power_clock_mode_o == MODE_EXT_CLK
        |-> conversion_strobe_o [*6]) else $error("external strobe too short");
    int_strobe_a: assert property (conv_start_o && power_clock_mode_o == MODE_INT_CLK |=> !conversion_strobe_o)
        else $error("internal strobe not low at start");
    dout_edge_a: assert property ($changed(serial_data_out_o) |-> !serial_clock_i)
        else $error("data out changed while serial clock high");
endmodule
bind ascb_top ascb_top_asserts u_ascb_top_asserts (.clk_sys_i, .rst_n_i, .chip_select_n_i,
    .serial_clock_i, .serial_data_out_o,
    .serial_data_out_oe_o, .conversion_strobe_o, .conversion_strobe_oe_o, .conv_start_o, .track_o,
    .hold_o, .pos_channel_o, .neg_channel_o, .neg_is_common_o, .power_clock_mode_o, .power_down_o);
`default_nettype wire

//--- tb/ascb_master.sv
/* Serial master model, clock polarity 0 and phase 0, 160 ns clock.
 * Assumes the bench calls its tasks one at a time. */
`default_nettype none
module ascb_master (
    output logic sclk_o,
    output logic cs_n_o,
    output logic din_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        din_o  = 1'b0;
    end
    task automatic sel();
        #80 cs_n_o = 1'b0;
    endtask
    // The data line no longer holds its last level once deselected.
    task automatic desel();
        #80 cs_n_o = 1'b1;
        din_o = ~din_o;
    endtask
    // Shifts n bits msb first, repeating v every 16; the clock stands low between calls.
    task automatic shift(input logic [15:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            din_o = v[i % 16];
            #80 sclk_o = 1'b1;
            #80 sclk_o = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

//--- tb/tb_ascb_top.sv
/* Testbench of ascb_top with the serial master model and a stub analog core.
 * Assumes the design, the checker and the master model are compiled first. */
`default_nettype none
module tb_ascb_top
    import ascb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i = 1'b0, rst_n_i = 1'b0, serial_clock_i, chip_select_n_i, serial_data_in_i;
    logic serial_data_out_o, serial_data_out_oe_o, conversion_strobe_o, conversion_strobe_oe_o;
    logic conv_start_o, track_o, hold_o, neg_is_common_o, bipolar_o, power_down_o, result_ready_o;
    logic [2:0] pos_channel_o, neg_channel_o;
    logic [1:0] power_clock_mode_o;
    logic result_valid_i = 1'b0, fill = 1'b0, push_en = 1'b0;
    logic [RESULT_W-1:0] result_data_i = 10'h000, kexp = 10'h2A5;
    logic [11:0] word;
    int error_cnt, compares, nconv, lim, fall, last, bitn, cyc;
    wire dout_w = serial_data_out_oe_o ? serial_data_out_o : 1'bz;
    always #10 clk_sys_i = ~clk_sys_i;
    ascb_master u_ascb_master (.sclk_o(serial_clock_i), .cs_n_o(chip_select_n_i), .din_o(serial_data_in_i));
    ascb_top u_ascb_top (.clk_sys_i, .rst_n_i, .serial_clock_i, .chip_select_n_i, .serial_data_in_i,
        .serial_data_out_o, .serial_data_out_oe_o, .conversion_strobe_o, .conversion_strobe_oe_o, .conv_start_o,
        .track_o, .hold_o, .pos_channel_o, .neg_channel_o, .neg_is_common_o, .bipolar_o, .power_clock_mode_o,
        .power_down_o, .result_valid_i, .result_data_i, .result_ready_o);
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic do_reset();
        rst_n_i = 1'b0;
        repeat (6) @(negedge clk_sys_i);
        rst_n_i = 1'b1;
        repeat (4) @(negedge clk_sys_i);
    endtask
    // Stub analog core: one word per conversion start, or a burst while filling.
    always @(negedge clk_sys_i) begin
        result_valid_i <= fill | (push_en & conv_start_o);
        result_data_i  <= 10'h2A5;
    end
    // Result bits are taken at the next fall, since the pins reach the design late.
    always @(negedge serial_clock_i) begin
        fall++;
        if (bitn > 0) begin
            word = {word[10:0], dout_w};
            bitn--;
            if (bitn == 0) chk(word, {(nconv <= lim) ? kexp : 10'h000, 2'b00});
        end
        if (!chip_select_n_i && conversion_strobe_o === 1'b1 && power_clock_mode_o === MODE_EXT_CLK) begin
            if (fall - last < 100) chk(12'(fall - last), 12'h00F);
            last = fall;
            nconv++;
            bitn = 12;
        end
    end
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 40000) begin
            error_cnt++;
            stop_test();
        end
    end
    initial begin
        lim = 32;
        do_reset();
        for (int i = 0; i < 128; i++) begin
            u_ascb_master.sel();
            u_ascb_master.shift(16'(8'h80 | i), 8 + i % 4);
            repeat (8) @(negedge clk_sys_i);
            chk({11'h000, serial_data_out_oe_o}, 12'h001);
            chk({pos_channel_o, neg_channel_o, neg_is_common_o, bipolar_o, power_clock_mode_o, power_down_o, 1'b0},
                {i[5], i[4], i[6], i[2] ? 3'h0 : {i[5], i[4], ~i[6]}, i[2], ~i[3], i[1:0], ~i[1], 1'b0});
            u_ascb_master.desel();
            repeat (6) @(negedge clk_sys_i);
            chk({11'h000, serial_data_out_oe_o}, 12'h000);
        end
        do_reset();
        fill <= 1'b1;
        repeat (40) @(negedge clk_sys_i);
        fill <= 1'b0;
        chk({11'h000, result_ready_o}, 12'h000);
        u_ascb_master.sel();
        u_ascb_master.shift(16'hFFFF, 503);
        chk(12'(nconv), 12'h021);
        chk({6'h00, pos_channel_o, neg_is_common_o, bipolar_o, power_down_o}, 12'h03C);
        u_ascb_master.desel();
        chk({11'h000, result_ready_o}, 12'h001);
        push_en <= 1'b1;
        kexp = 10'h0A5;
        lim = 1000;
        last = -1000;
        u_ascb_master.sel();
        u_ascb_master.shift(16'h00F7, 8);
        u_ascb_master.shift(16'h0000, 16);
        u_ascb_master.desel();
        chk(12'(nconv), 12'h022);
        // Internal clock byte: the strobe must come back high once a result is queued.
        u_ascb_master.sel();
        u_ascb_master.shift(16'h00F6, 8);
        repeat (8) @(negedge clk_sys_i);
        chk({11'h000, conversion_strobe_o}, 12'h001);
        stop_test();
    end
endmodule
`default_nettype wire
